// file: design/pllc_pkg.sv
`default_nettype none
package pllc_pkg;

   // Clock and reset timing
   localparam int unsigned CLK_PERIOD_NS = 5;                 // 200 MHz system clock
   localparam int unsigned RST_MIN_NS    = 10;                // Least low time of the loop reset
   localparam int unsigned RST_MIN_CYC   = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0]  RST_HOLD_CYC  = 4'(RST_MIN_CYC);   // Countdown loaded when the reset falls; the reset stays low one cycle more

   // Lock detection
   localparam logic [3:0]  LOCK_PERIODS  = 4'h8;              // Matching periods before lock
   localparam logic [15:0] PER_TOL       = 16'h0001;          // Allowed period jitter in cycles
   localparam int unsigned MAX_FBK_PRODUCT = 255;             // Ceiling on M x O x Cfbk

   // Reference inputs: low half pads, high half core tree
   localparam int unsigned REF_CORE_BIT  = 1;

   // Register offsets of the fabric controller
   localparam logic [7:0] REG_CTRL      = 8'h00;              // [0] run
   localparam logic [7:0] REG_SEL       = 8'h04;              // [1:0] new reference select
   localparam logic [7:0] REG_STATUS    = 8'h08;              // [0] lock [1] busy [3:2] sel [4] loop reset high
   localparam logic [7:0] REG_IRQ_STAT  = 8'h0C;              // Sticky events, write one to clear
   localparam logic [7:0] REG_IRQ_MASK  = 8'h10;              // Same layout as the sticky events
   localparam logic [7:0] REG_MULT      = 8'h14;              // [7:0] M [11:8] N [15:12] O
   localparam logic [7:0] REG_DIV       = 8'h18;              // Three 8-bit fields, C minus one
   localparam logic [7:0] REG_MODE      = 8'h1C;              // [1:0] src [3:2] fb [5:4] fix [7:6] fbk

   // Event bit positions
   localparam int unsigned IRQ_LOCK_GAIN = 0;
   localparam int unsigned IRQ_LOCK_LOST = 1;
   localparam int unsigned IRQ_CFG_REJ   = 2;

   // Reset values of the settings
   localparam logic [7:0] RST_MULT = 8'h01;
   localparam logic [3:0] RST_PRE  = 4'h1;
   localparam logic [3:0] RST_POST = 4'h1;
   localparam logic [7:0] RST_DIV  = 8'h00;

   // Reference source setting
   typedef enum logic [1:0] {
      SRC_PIN  = 2'b00,
      SRC_CORE = 2'b01,
      SRC_DYN  = 2'b10
   } pllc_src_type;

   // Feedback mode
   typedef enum logic [1:0] {
      FB_INTERNAL = 2'b00,
      FB_LOCAL    = 2'b01,
      FB_CORE     = 2'b10
   } pllc_fb_type;

   // Select change sequence of the controller
   typedef enum logic [1:0] {
      SEQ_IDLE   = 2'b00,
      SEQ_SWITCH = 2'b01,
      SEQ_HOLD   = 2'b10
   } pllc_seq_type;

endpackage
`default_nettype wire

// file: design/pllc_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface pllc_link_if;
   import pllc_pkg::*;

   logic              pll_reset_n;          // Loop reset, low holds the loop
   logic [1:0]        ref_clk_select;       // Dynamic reference choice
   logic              fabric_feedback_clk;  // Feedback returned from the fabric
   logic              synth_clk_out_a;      // Synthesized output a
   logic              synth_clk_out_b;      // Synthesized output b
   logic              synth_clk_out_c;      // Synthesized output c
   logic              pll_locked;           // Lock indicator
   logic [7:0]        cfg_mult;             // Multiplier M
   logic [3:0]        cfg_pre;              // Pre-divider N
   logic [3:0]        cfg_post;             // Post divider O
   logic [2:0][7:0]   cfg_div;              // Output dividers, C minus one
   pllc_src_type      cfg_src;              // Reference source setting
   pllc_fb_type       cfg_fb;               // Feedback mode
   logic [1:0]        cfg_fix;              // Fixed reference index
   logic [1:0]        cfg_fbk_idx;          // Output used as feedback

   // Documented loop end
   modport dev (
      input  pll_reset_n, ref_clk_select, fabric_feedback_clk,
      input  cfg_mult, cfg_pre, cfg_post, cfg_div, cfg_src, cfg_fb, cfg_fix, cfg_fbk_idx,
      output synth_clk_out_a, synth_clk_out_b, synth_clk_out_c, pll_locked
   );

   // Fabric controller end
   modport fab (
      output pll_reset_n, ref_clk_select, fabric_feedback_clk,
      output cfg_mult, cfg_pre, cfg_post, cfg_div, cfg_src, cfg_fb, cfg_fix, cfg_fbk_idx,
      input  synth_clk_out_a, synth_clk_out_b, synth_clk_out_c, pll_locked
   );

endinterface
`default_nettype wire

// file: design/pllc_device.sv
`timescale 1ns/100ps
`default_nettype none
module pllc_device
   import pllc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   pllc_link_if.dev        lnk,
   input  wire logic [3:0] ref_clk_in,
   output logic      [2:0] global_clock_net
);

   // Whole state of the loop model
   typedef struct packed {
      logic [3:0]       ref_s1;     // Pad synchroniser, first stage
      logic [3:0]       ref_s2;     // Pad synchroniser, second stage
      logic [3:0]       ref_d;      // Edge detect delay
      logic             fb_d;       // Feedback edge detect delay
      logic [1:0]       sel;        // Reference in use
      logic             armed;      // First reference edge seen
      logic             per_ok;     // Period measured
      logic [15:0]      per_cnt;    // Cycles since last edge
      logic [15:0]      period;     // Last measured period
      logic [3:0]       match_cnt;  // Matching periods in a row
      logic [19:0]      fb_gap;     // Cycles since last feedback edge
      logic             locked;     // Lock indicator
      logic [2:0]       clk_out;    // Synthesized clocks
      logic [2:0][39:0] acc;        // Phase accumulators
   } pllc_dev_state_type;

   localparam pllc_dev_state_type DEV_RST = '0;

   pllc_dev_state_type state_ff;    // Registered state
   pllc_dev_state_type nxt_state;   // Next state

   // Reference chosen by the source setting
   function automatic logic [1:0] eff_sel(pllc_src_type src, logic [1:0] fix, logic [1:0] dyn);
      logic [1:0] r;
      r = fix;
      case (src)
         SRC_PIN:  r = {1'b0, fix[0]};                    // Pads only
         SRC_CORE: r = {1'b1, fix[0]};                    // Core tree only
         SRC_DYN:  r = dyn;                               // Select bus
         default:  r = fix;
      endcase
      return r;
   endfunction

   // Period match within the jitter allowance
   function automatic logic near_eq(logic [15:0] a, logic [15:0] b);
      return (a >= b) ? ((a - b) <= PER_TOL) : ((b - a) <= PER_TOL);
   endfunction

   // Twice the output rate numerator
   function automatic logic [39:0] out_num(pllc_fb_type fb, logic [7:0] m, logic [7:0] cfbk_m1);
      logic [39:0] r;
      r = 40'(m) << 1;
      if (fb != FB_INTERNAL) begin
         r = (40'(m) * (40'(cfbk_m1) + 40'h1)) << 1;      // Feedback divider multiplies
      end
      return r;
   endfunction

   // Output rate denominator scaled by the reference period
   function automatic logic [39:0] out_den(pllc_fb_type fb, logic [3:0] n, logic [3:0] o,
                                           logic [7:0] c_m1, logic [15:0] p);
      logic [39:0] r;
      r = 40'(n) * (40'(c_m1) + 40'h1) * 40'(p);
      if (fb == FB_INTERNAL) begin
         r = r * 40'(o);                                  // Post divider only inside
      end
      return r;
   endfunction

   // Next state
   always_comb begin
      logic        ref_edge;
      logic        fb_edge;
      logic        fb_stall;
      logic        lost;
      logic [39:0] num;
      logic [39:0] den;
      logic [39:0] sum;
      ref_edge = 1'b0;
      fb_edge  = 1'b0;
      fb_stall = 1'b0;
      lost     = 1'b0;
      num      = '0;
      den      = '0;
      sum      = '0;
      nxt_state = state_ff;
      // Pads come from outside, two stages first
      nxt_state.ref_s1 = ref_clk_in;
      nxt_state.ref_s2 = state_ff.ref_s1;
      nxt_state.ref_d  = state_ff.ref_s2;
      // Feedback comes from a fabric flop on this clock
      nxt_state.fb_d   = lnk.fabric_feedback_clk;
      ref_edge = state_ff.ref_s2[state_ff.sel] & ~state_ff.ref_d[state_ff.sel];
      fb_edge  = lnk.fabric_feedback_clk & ~state_ff.fb_d;
      if (rst || !lnk.pll_reset_n) begin
         // Held in reset: clear all but the synchroniser and edge detect flops, take the new select
         nxt_state.sel       = eff_sel(lnk.cfg_src, lnk.cfg_fix, lnk.ref_clk_select);
         nxt_state.armed     = 1'b0;
         nxt_state.per_ok    = 1'b0;
         nxt_state.per_cnt   = '0;
         nxt_state.period    = '0;
         nxt_state.match_cnt = '0;
         nxt_state.fb_gap    = '0;
         nxt_state.locked    = 1'b0;
         nxt_state.clk_out   = '0;
         nxt_state.acc       = '0;
      end else begin
         // Period measurement of the chosen reference
         if (ref_edge) begin
            nxt_state.per_cnt = 16'h0001;
            nxt_state.period  = state_ff.per_cnt;
            nxt_state.armed   = 1'b1;
            nxt_state.per_ok  = state_ff.armed;
            if (state_ff.per_ok && near_eq(state_ff.per_cnt, state_ff.period)) begin
               if (state_ff.match_cnt != 4'hF) begin
                  nxt_state.match_cnt = state_ff.match_cnt + 4'h1;
               end
            end else begin
               nxt_state.match_cnt = '0;
               lost = state_ff.per_ok;                    // Reference period moved
            end
         end else if (state_ff.per_cnt != 16'hFFFF) begin
            nxt_state.per_cnt = state_ff.per_cnt + 16'h0001;
         end
         // Feedback watchdog, only meaningful with core feedback
         if (fb_edge) begin
            nxt_state.fb_gap = '0;
         end else if (state_ff.fb_gap != 20'hFFFFF) begin
            nxt_state.fb_gap = state_ff.fb_gap + 20'h00001;
         end
         fb_stall = (lnk.cfg_fb == FB_CORE) && (state_ff.fb_gap > {state_ff.period, 4'h0});
         // Reference vanished: no edge within two periods
         if (state_ff.per_ok && (state_ff.per_cnt > {state_ff.period[14:0], 1'b0})) begin
            lost = 1'b1;
         end
         if (fb_stall) begin
            lost = 1'b1;
         end
         // Output synthesis, one accumulator per output
         for (int i = 0; i < 3; i++) begin
            // Feedback index 3 stands for output a, as on the fabric side
            num = out_num(lnk.cfg_fb, lnk.cfg_mult, lnk.cfg_div[(lnk.cfg_fbk_idx == 2'h3) ? 2'h0 : lnk.cfg_fbk_idx]);
            den = out_den(lnk.cfg_fb, lnk.cfg_pre, lnk.cfg_post, lnk.cfg_div[i], state_ff.period);
            sum = state_ff.acc[i] + num;
            if (state_ff.per_ok && (den != 40'h0)) begin
               if (sum >= den) begin
                  sum = sum - den;
                  nxt_state.clk_out[i] = ~state_ff.clk_out[i];
                  if (sum >= den) begin
                     sum = '0;                            // Rate above clk/2 is clamped
                  end
               end
               nxt_state.acc[i] = sum;
            end
         end
         // Lock state
         if (lost) begin
            nxt_state.locked    = 1'b0;                   // Loss of lock
            nxt_state.match_cnt = '0;
         end else if (!state_ff.locked && (state_ff.match_cnt >= LOCK_PERIODS) && !fb_stall) begin
            nxt_state.locked = 1'b1;                      // Lock achieved
            if (lnk.cfg_fb != FB_INTERNAL) begin
               // Restart outputs on the reference edge
               nxt_state.acc     = '0;
               nxt_state.clk_out = '0;
            end
            // Internal feedback keeps running free
         end
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (rst) begin
         state_ff <= DEV_RST;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Outputs straight from the state register
   assign lnk.synth_clk_out_a = state_ff.clk_out[0];
   assign lnk.synth_clk_out_b = state_ff.clk_out[1];
   assign lnk.synth_clk_out_c = state_ff.clk_out[2];
   assign lnk.pll_locked      = state_ff.locked;
   assign global_clock_net    = state_ff.clk_out;         // Into the core clock tree

endmodule
`default_nettype wire

// file: design/pllc_fabric.sv
`timescale 1ns/100ps
`default_nettype none
module pllc_fabric
   import pllc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   pllc_link_if.fab         lnk,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   output logic             irq
);

   // Whole state of the controller
   typedef struct packed {
      logic             run;        // Software wants the loop running
      pllc_seq_type     seq;        // Select change sequence
      logic [1:0]       sel_req;    // Requested reference
      logic [1:0]       sel;        // Select driven to the loop
      logic             rst_n;      // Loop reset driven out
      logic [3:0]       hold;       // Reset low time still owed
      logic             fbk;        // Returned feedback clock
      logic             lock_d;     // Lock delayed for edges
      logic [7:0]       mult;
      logic [3:0]       pre;
      logic [3:0]       post;
      logic [2:0][7:0]  div;
      pllc_src_type     src;
      pllc_fb_type      fb;
      logic [1:0]       fix;
      logic [1:0]       fbk_idx;
      logic [2:0]       irq_stat;   // Sticky events
      logic [2:0]       irq_mask;   // Event enables
      logic             irq;
      logic [31:0]      rdata;
   } pllc_fab_state_type;

   localparam pllc_fab_state_type FAB_RST = '{
      run: 1'b0, seq: SEQ_IDLE, sel_req: 2'h0, sel: 2'h0, rst_n: 1'b0, hold: RST_HOLD_CYC,
      fbk: 1'b0, lock_d: 1'b0, mult: RST_MULT, pre: RST_PRE, post: RST_POST,
      div: {3{RST_DIV}}, src: SRC_PIN, fb: FB_INTERNAL, fix: 2'h0, fbk_idx: 2'h0,
      irq_stat: 3'h0, irq_mask: 3'h0, irq: 1'b0, rdata: 32'h0
   };

   pllc_fab_state_type state_ff;    // Registered state
   pllc_fab_state_type nxt_state;   // Next state

   // Settings legal for the loop
   function automatic logic cfg_ok(pllc_fab_state_type c);
      logic [19:0] prod;
      // Index 3 picks output a; a raw index 3 would read an unknown divider
      prod = 20'(c.mult) * 20'(c.post) * (20'(c.div[(c.fbk_idx == 2'h3) ? 2'h0 : c.fbk_idx]) + 20'h1);
      cfg_ok = (c.pre != 4'h0) && (c.mult != 8'h0) &&
               ((c.post == 4'h1) || (c.post == 4'h2) || (c.post == 4'h4) || (c.post == 4'h8));
      if ((c.fb != FB_INTERNAL) && (prod > 20'(MAX_FBK_PRODUCT))) begin
         cfg_ok = 1'b0;                                   // Refused, product too large
      end
   endfunction

   // Next state
   always_comb begin
      pllc_fab_state_type cand;
      logic [2:0]         ev;
      logic [2:0]         clr;
      logic [2:0]         outs;
      cand = state_ff;
      ev   = '0;
      clr  = '0;
      outs = {lnk.synth_clk_out_c, lnk.synth_clk_out_b, lnk.synth_clk_out_a};
      nxt_state = state_ff;
      nxt_state.lock_d = lnk.pll_locked;
      // Route the chosen output back as feedback
      nxt_state.fbk = (state_ff.fbk_idx == 2'h3) ? outs[0] : outs[state_ff.fbk_idx];
      // Register writes
      if (reg_wr) begin
         case (reg_addr)
            REG_CTRL:     nxt_state.run = reg_wdata[0];
            REG_SEL: begin
               if (state_ff.seq == SEQ_IDLE) begin
                  nxt_state.sel_req = reg_wdata[1:0];
                  nxt_state.seq     = SEQ_SWITCH;         // Reset goes low first
               end
            end
            REG_IRQ_STAT: clr = reg_wdata[2:0];
            REG_IRQ_MASK: nxt_state.irq_mask = reg_wdata[2:0];
            REG_MULT: begin
               cand.mult = reg_wdata[7:0];
               cand.pre  = reg_wdata[11:8];
               cand.post = reg_wdata[15:12];
            end
            REG_DIV:      cand.div = reg_wdata[23:0];
            REG_MODE: begin
               cand.src     = pllc_src_type'(reg_wdata[1:0]);
               cand.fb      = pllc_fb_type'(reg_wdata[3:2]);
               cand.fix     = reg_wdata[5:4];
               cand.fbk_idx = reg_wdata[7:6];
            end
            default: ;
         endcase
         if ((reg_addr == REG_MULT) || (reg_addr == REG_DIV) || (reg_addr == REG_MODE)) begin
            if (cfg_ok(cand)) begin
               nxt_state.mult    = cand.mult;
               nxt_state.pre     = cand.pre;
               nxt_state.post    = cand.post;
               nxt_state.div     = cand.div;
               nxt_state.src     = cand.src;
               nxt_state.fb      = cand.fb;
               nxt_state.fix     = cand.fix;
               nxt_state.fbk_idx = cand.fbk_idx;
            end else begin
               ev[IRQ_CFG_REJ] = 1'b1;                    // Old settings stay
            end
         end
      end
      // Select change sequence
      case (state_ff.seq)
         SEQ_SWITCH: begin
            nxt_state.sel = state_ff.sel_req;             // Changed only while reset is low
            nxt_state.seq = SEQ_HOLD;
         end
         SEQ_HOLD: begin
            if (state_ff.hold == 4'h0) begin
               nxt_state.seq = SEQ_IDLE;                  // Select stable, reset may go
            end
         end
         default: ;
      endcase
      // Reset with a least low time
      nxt_state.rst_n = state_ff.run && (state_ff.seq == SEQ_IDLE) && (nxt_state.seq == SEQ_IDLE) &&
                        (state_ff.hold == 4'h0);
      if (state_ff.rst_n && !nxt_state.rst_n) begin
         nxt_state.hold = RST_HOLD_CYC;
      end else if (state_ff.hold != 4'h0) begin
         nxt_state.hold = state_ff.hold - 4'h1;
      end
      // Lock events, set wins over clear
      ev[IRQ_LOCK_GAIN] = lnk.pll_locked & ~state_ff.lock_d;
      ev[IRQ_LOCK_LOST] = ~lnk.pll_locked & state_ff.lock_d;
      nxt_state.irq_stat = (state_ff.irq_stat & ~clr) | ev;
      nxt_state.irq      = |(nxt_state.irq_stat & nxt_state.irq_mask);
      // Read data, one cycle after the strobe
      nxt_state.rdata = '0;
      if (reg_rd) begin
         case (reg_addr)
            REG_CTRL:     nxt_state.rdata = {31'h0, state_ff.run};
            REG_SEL:      nxt_state.rdata = {30'h0, state_ff.sel_req};
            REG_STATUS:   nxt_state.rdata = {27'h0, state_ff.rst_n, state_ff.sel,
                                             (state_ff.seq != SEQ_IDLE), lnk.pll_locked};
            REG_IRQ_STAT: nxt_state.rdata = {29'h0, state_ff.irq_stat};
            REG_IRQ_MASK: nxt_state.rdata = {29'h0, state_ff.irq_mask};
            REG_MULT:     nxt_state.rdata = {16'h0, state_ff.post, state_ff.pre, state_ff.mult};
            REG_DIV:      nxt_state.rdata = {8'h0, state_ff.div};
            REG_MODE:     nxt_state.rdata = {24'h0, state_ff.fbk_idx, state_ff.fix,
                                             state_ff.fb, state_ff.src};
            default:      nxt_state.rdata = '0;
         endcase
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (rst) begin
         state_ff <= FAB_RST;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Outputs straight from the state register
   assign lnk.pll_reset_n         = state_ff.rst_n;
   assign lnk.ref_clk_select      = state_ff.sel;
   assign lnk.fabric_feedback_clk = state_ff.fbk;
   assign lnk.cfg_mult            = state_ff.mult;
   assign lnk.cfg_pre             = state_ff.pre;
   assign lnk.cfg_post            = state_ff.post;
   assign lnk.cfg_div             = state_ff.div;
   assign lnk.cfg_src             = state_ff.src;
   assign lnk.cfg_fb              = state_ff.fb;
   assign lnk.cfg_fix             = state_ff.fix;
   assign lnk.cfg_fbk_idx         = state_ff.fbk_idx;
   assign reg_rdata               = state_ff.rdata;
   assign irq                     = state_ff.irq;

endmodule
`default_nettype wire

// file: bench/pllc_properties.sv
`timescale 1ns/100ps
`default_nettype none
module pllc_properties
   import pllc_pkg::*;
(
   input wire logic            clk,
   input wire logic            rst,
   input wire logic            pll_reset_n,
   input wire logic [1:0]      ref_clk_select,
   input wire logic            fabric_feedback_clk,
   input wire logic            synth_clk_out_a,
   input wire logic            synth_clk_out_b,
   input wire logic            synth_clk_out_c,
   input wire logic            pll_locked,
   input wire logic [7:0]      cfg_mult,
   input wire logic [3:0]      cfg_post,
   input wire logic [2:0][7:0] cfg_div,
   input wire pllc_fb_type     cfg_fb,
   input wire logic [1:0]      cfg_fbk_idx
);
   // Index 3 falls back to output a
   wire logic [1:0]  sel  = (cfg_fbk_idx == 2'h3) ? 2'h0 : cfg_fbk_idx;
   wire logic [2:0]  outs = {synth_clk_out_c, synth_clk_out_b, synth_clk_out_a};
   wire logic [31:0] prod = 32'(cfg_mult) * 32'(cfg_post) * (32'(cfg_div[sel]) + 32'h1);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   a_lock_in_reset: assert property (!pll_reset_n |=> !pll_locked) else $error("lock in reset");
   a_quiet_in_reset: assert property (!pll_reset_n |=> outs == 3'h0) else $error("outputs in reset");
   a_reset_width: assert property ($fell(pll_reset_n) |-> !pll_reset_n [*2]) else $error("short reset");
   a_select_held: assert property (pll_reset_n |-> $stable(ref_clk_select)) else $error("select moved");
   a_lock_late: assert property ($rose(pll_locked) |-> $past(pll_reset_n, 16)) else $error("early lock");
   a_fbk_copy: assert property (cfg_fb == FB_CORE && $stable(cfg_fb) && $stable(sel)
      |-> fabric_feedback_clk == $past(outs[sel])) else $error("feedback wrong");
   a_fbk_product: assert property (cfg_fb != FB_INTERNAL |-> prod <= 32'(MAX_FBK_PRODUCT))
      else $error("product");
   a_cfg_legal: assert property (cfg_mult != 8'h0 && $onehot(cfg_post)) else $error("bad setting");
   c_lock: cover property ($rose(pll_locked));
   c_core_lock: cover property (cfg_fb == FB_CORE && pll_locked);
   c_sel_switch: cover property (!pll_reset_n && $changed(ref_clk_select));
endmodule
`default_nettype wire

// file: bench/test_pll_reference_and_lock_control.sv
`timescale 1ns/100ps
`default_nettype none
module test_pll_reference_and_lock_control;
   import pllc_pkg::*;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [3:0]  ref_clk_in = 4'h0;
   logic [3:0]  ref_on = 4'h7;     // Reference 3 dead at first
   logic [3:0]  ref_cnt = 4'h0;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic        irq;
   logic [2:0]  global_clock_net;
   int          miscompares = 0;
   int          n_tests = 0;
   logic [7:0]  modes [4] = '{8'h10, 8'h11, 8'hC6, 8'h4A};  // Pin, core, local fb idx 3, core fb from b
   pllc_link_if lnk ();
   pllc_device i_pllc_device (.clk, .rst, .lnk, .ref_clk_in, .global_clock_net);
   pllc_fabric i_pllc_fabric (.clk, .rst, .lnk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq);
   pllc_properties i_props (.clk, .rst, .pll_reset_n(lnk.pll_reset_n), .ref_clk_select(lnk.ref_clk_select),
      .fabric_feedback_clk(lnk.fabric_feedback_clk), .synth_clk_out_a(lnk.synth_clk_out_a),
      .synth_clk_out_b(lnk.synth_clk_out_b), .synth_clk_out_c(lnk.synth_clk_out_c), .pll_locked(lnk.pll_locked),
      .cfg_mult(lnk.cfg_mult), .cfg_post(lnk.cfg_post), .cfg_div(lnk.cfg_div), .cfg_fb(lnk.cfg_fb),
      .cfg_fbk_idx(lnk.cfg_fbk_idx));
   always #2.5 clk = ~clk;
   // References: period of 16 cycles
   always @(posedge clk) ref_cnt <= ref_cnt + 4'h1;
   always @(posedge clk) ref_clk_in <= ref_on & {4{ref_cnt[3]}};
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One bus cycle; a read checks the masked data of the next cycle
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m = 32'h0);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= w;
      reg_rd <= !w;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      @(negedge clk);
      if (!w) chk($sformatf("reg %h", a), d, reg_rdata & m);
   endtask
   // Irq is registered on the same edge as the sticky bits; allow two edges
   task automatic irq_is(input logic e);
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk("irq", {31'h0, e}, {31'h0, irq});
   endtask
   task automatic wait_lock();
      // Looked at on the falling edge, where the lock flop has settled
      for (int i = 0; i < 1000 && lnk.pll_locked !== 1'b1; i++) @(negedge clk);
   endtask
   // M=2, N=O=1, P=16: half period 4*C with C = 1, 2, 4
   task automatic rates();
      int t [3];
      int bad;
      logic [2:0] prev;
      t = '{0, 0, 0};
      bad = 0;
      prev = global_clock_net;
      repeat (160) begin
         @(negedge clk);
         bad += int'(global_clock_net !== {lnk.synth_clk_out_c, lnk.synth_clk_out_b, lnk.synth_clk_out_a});
         for (int i = 0; i < 3; i++) t[i] += int'(global_clock_net[i] !== prev[i]);
         prev = global_clock_net;
      end
      chk("global net", 32'h0, 32'(bad));
      for (int i = 0; i < 3; i++) chk("toggles", 32'h1, 32'((t[i] - 160 / (4 << i)) inside {[-1:1]}));
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Hang guard, far beyond the few thousand cycles needed
   initial begin
      #150000;
      miscompares++;
      finish_test();
   end
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      bus(0, REG_STATUS, 32'h0, 32'h1F);
      bus(0, 8'h20, 32'h0, 32'hFFFFFFFF);
      bus(1, REG_MULT, 32'h1102);
      // Feedback is still internal here, so any C divider is allowed
      bus(1, REG_DIV, 32'h030100);
      bus(1, REG_MODE, 32'h02);
      bus(1, REG_IRQ_MASK, 32'h3);
      bus(1, REG_CTRL, 32'h1);
      wait_lock();
      bus(0, REG_STATUS, 32'h1, 32'h1);
      irq_is(1'b1);
      $display("lock done");
      rates();
      $display("rates done");
      bus(1, REG_SEL, 32'h3);
      repeat (300) @(posedge clk);
      bus(0, REG_STATUS, 32'h0C, 32'h0D);
      bus(0, REG_IRQ_STAT, 32'h2, 32'h2);
      ref_on <= 4'hF;
      wait_lock();
      bus(0, REG_STATUS, 32'h0D, 32'h0D);
      $display("select done");
      bus(1, REG_MODE, 32'h06);
      bus(1, REG_IRQ_STAT, 32'h7);
      bus(1, REG_MULT, 32'h21FF);
      bus(0, REG_MULT, 32'h1102, 32'hFFFF);
      bus(0, REG_IRQ_STAT, 32'h4, 32'h4);
      bus(1, REG_IRQ_MASK, 32'h4);
      irq_is(1'b1);
      bus(1, REG_IRQ_STAT, 32'h4);
      irq_is(1'b0);
      $display("refusal done");
      foreach (modes[i]) begin
         bus(1, REG_MODE, {24'h0, modes[i]});
         bus(1, REG_CTRL, 32'h0);
         repeat (4) @(posedge clk);
         bus(0, REG_STATUS, 32'h0, 32'h1);
         bus(1, REG_CTRL, 32'h1);
         wait_lock();
         bus(0, REG_STATUS, 32'h1, 32'h1);
      end
      $display("modes done");
      finish_test();
   end
endmodule
`default_nettype wire
